// [core/fslg_pkg.sv]
// Package for the flash security lock guard: map constants, codes and carriers.
// Assumes a 32 kB flash with 512-byte pages and the lock byte at the top of user space.
package fslg_pkg;

    localparam int          ADDR_W         = 15;
    localparam int          PAGE_BITS      = 9;
    localparam int          PAGE_W         = ADDR_W - PAGE_BITS;
    localparam logic [14:0] LOCK_BYTE_ADDR = 15'h7DFF;
    localparam logic [14:0] RESERVED_BASE  = 15'h7E00;
    localparam logic [5:0]  LOCK_PAGE      = 6'h3E;
    localparam logic [7:0]  KEY_FIRST      = 8'hA5;
    localparam logic [7:0]  KEY_SECOND     = 8'hF1;
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

    // Register offsets on the plain register port.
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_KEY        = 4'h1;
    localparam logic [3:0]  REG_RESET_SOURCE_REGISTER     = 4'h2;
    localparam logic [3:0]  REG_STATUS     = 4'h3;

    // Field positions.
    localparam int          CTRL_WE_BIT    = 0;
    localparam int          CTRL_EE_BIT    = 1;
    localparam int          RST_POR_BIT    = 1;
    localparam int          RST_FERR_BIT   = 6;

    localparam logic [1:0]  CTRL_RESET     = 2'h0;

    typedef enum logic [1:0] {
        FSLG_OP_READ,
        FSLG_OP_WRITE,
        FSLG_OP_ERASE
    } fslg_op_t;

    typedef enum logic [1:0] {
        FSLG_ALLOW,
        FSLG_IGNORE,
        FSLG_RESET
    } fslg_verdict_t;

    // Request from the CPU core or the debug port.
    typedef struct packed {
        logic               valid;
        logic               fromDebug;
        fslg_op_t           op;
        logic [ADDR_W-1:0]  addr;
        logic [7:0]         data;
    } fslg_req_t;

    // Request passed on to the flash array.
    typedef struct packed {
        logic               valid;
        fslg_op_t           op;
        logic [ADDR_W-1:0]  addr;
        logic [7:0]         data;
    } fslg_flash_t;

endpackage

// [core/fslg_guard.sv]
// Flash security lock guard: judges each flash read, write and erase.
// Assumes the core stalls during flash work and holds a request for one cycle only.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps

module fslg_guard
    import fslg_pkg::*;
(
    // Clock and reset.
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // Register port.
    input  wire logic [3:0]         regAddr,
    input  wire logic [7:0]         regWdata,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic [7:0]              regRdata,
    // Requests and current fetch address.
    input  wire fslg_req_t          req,
    input  wire logic               xmoveRead,
    input  wire logic [ADDR_W-1:0]  fetchAddr,
    input  wire logic               debugFullErase,
    // Supply monitor state.
    input  wire logic               supplyMonOn,
    input  wire logic               supplyMonResetEn,
    // Lock byte as stored in the flash array.
    input  wire logic [7:0]         flashLockByte,
    // Flash side.
    output fslg_flash_t             flashReq,
    output logic                    xramRead,
    output logic                    flashErrorReset,
    output logic                    flashBusy,
    output logic                    irqHold,
    input  wire logic               flashDone
);

    logic [1:0]        ctrl_q;
    logic              keyFirst_q;
    logic              keyArmed_q;
    logic              keyDead_q;
    logic [7:0]        reset_source_register_q;
    logic              ferrPending_q;
    logic [PAGE_W-1:0] lockCount_q;
    logic              anyLocked_q;
    logic              loaded_q;
    logic              busy_q;
    logic [7:0]        regRdata_q;
    fslg_flash_t       flashReq_q;
    logic              errRst_q;

    fslg_verdict_t     verdict;
    logic              isModify;
    logic              isErase;

    function automatic logic pageLocked(input logic [ADDR_W-1:0] a,
                                        input logic [PAGE_W-1:0] cnt);
        pageLocked = (a[ADDR_W-1:PAGE_BITS] < cnt);
    endfunction

    // lock byte load
    // The boundary is taken once after reset, so a firmware rewrite acts only next time.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lockCount_q <= '0;
            anyLocked_q <= 1'b0;
            loaded_q    <= 1'b0;
        end else if (!loaded_q) begin
            lockCount_q <= PAGE_W'(~flashLockByte);
            anyLocked_q <= (flashLockByte != ERASED_BYTE);
            loaded_q    <= 1'b1;
        end
    end

    assign isModify = (req.op != FSLG_OP_READ);

    // A firmware write with erase enable set wipes a page, so it is judged as an erase.
    assign isErase  = (req.op == FSLG_OP_ERASE)
                      || (req.op == FSLG_OP_WRITE && ctrl_q[CTRL_EE_BIT] && !req.fromDebug);

    always_comb begin
        logic onLockPage;
        logic tgtLocked;
        logic runLocked;
        logic reserved;
        logic isLockByte;
        onLockPage = (req.addr[ADDR_W-1:PAGE_BITS] == LOCK_PAGE);
        tgtLocked  = pageLocked(req.addr, lockCount_q);
        runLocked  = pageLocked(fetchAddr, lockCount_q);
        reserved   = (req.addr >= RESERVED_BASE);
        isLockByte = (req.addr == LOCK_BYTE_ADDR);
        verdict    = FSLG_ALLOW;
        if (!req.valid || !loaded_q) begin
            verdict = FSLG_IGNORE;
        end else if (req.fromDebug) begin
            if (reserved) begin
                verdict = FSLG_IGNORE;
            end else if (isLockByte && req.op == FSLG_OP_WRITE) begin
                verdict = FSLG_IGNORE;
            end else if (onLockPage && anyLocked_q) begin
                verdict = FSLG_IGNORE;
            end else if (tgtLocked) begin
                verdict = FSLG_IGNORE;
            end
        end else begin
            if (reserved) begin
                verdict = FSLG_RESET;
            end else if (isModify && !(supplyMonOn && supplyMonResetEn)) begin
                verdict = FSLG_RESET;
            end else if (onLockPage && isErase) begin
                verdict = FSLG_RESET;
            end else if (isLockByte && req.op == FSLG_OP_WRITE && anyLocked_q) begin
                verdict = FSLG_RESET;
            end else if ((tgtLocked || (onLockPage && anyLocked_q)) && !runLocked) begin
                verdict = FSLG_RESET;
            end else if (isModify && (!ctrl_q[CTRL_WE_BIT] || !keyArmed_q)) begin
                verdict = FSLG_IGNORE;
            end else if (req.op == FSLG_OP_ERASE && !ctrl_q[CTRL_EE_BIT]) begin
                verdict = FSLG_IGNORE;
            end
        end
    end

    // Control bits and key sequence.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_q     <= CTRL_RESET;
            keyFirst_q <= 1'b0;
            keyArmed_q <= 1'b0;
            keyDead_q  <= 1'b0;
        end else begin
            if (regWr && regAddr == REG_CTRL) begin
                ctrl_q <= regWdata[1:0];
            end
            if (req.valid && !req.fromDebug && isModify) begin
                keyArmed_q <= 1'b0;
                keyFirst_q <= 1'b0;
                if (!keyArmed_q) begin
                    keyDead_q <= 1'b1;
                end
            end else if (regWr && regAddr == REG_KEY && !keyDead_q) begin
                if (!keyFirst_q && regWdata == KEY_FIRST) begin
                    keyFirst_q <= 1'b1;
                end else if (keyFirst_q && regWdata == KEY_SECOND) begin
                    keyFirst_q <= 1'b0;
                    keyArmed_q <= 1'b1;
                end else begin
                    keyDead_q  <= 1'b1;
                    keyFirst_q <= 1'b0;
                end
            end
        end
    end

    // flash error flag
    // The flag lives through the flash-error reset; only a power-on clear is outside.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reset_source_register_q      <= {1'b0, ferrPending_q, 6'h00};
        end else if (regWr && regAddr == REG_RESET_SOURCE_REGISTER) begin
            reset_source_register_q      <= regWdata & ~(8'h01 << RST_FERR_BIT);
        end
    end

    // The pending marker is not reset by rst_n, so it carries the cause across.
    // It drops only at the first edge after release, once the reset has taken it.
    always_ff @(posedge core_clk) begin
        if (verdict == FSLG_RESET) begin
            ferrPending_q <= 1'b1;
        end else if (rst_n && !loaded_q) begin
            ferrPending_q <= 1'b0;
        end
    end

    // Flash-side request and error reset.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flashReq_q <= '0;
            errRst_q   <= 1'b0;
            busy_q     <= 1'b0;
        end else begin
            flashReq_q.valid <= (verdict == FSLG_ALLOW);
            flashReq_q.op    <= isErase ? FSLG_OP_ERASE : req.op;
            flashReq_q.addr  <= req.addr;
            flashReq_q.data  <= req.data;
            errRst_q         <= (verdict == FSLG_RESET);
            if (verdict == FSLG_ALLOW && isModify) begin
                busy_q <= 1'b1;
            end else if (flashDone) begin
                busy_q <= 1'b0;
            end
        end
    end

    // Debug full erase wipes the array; the guard itself needs nothing more.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            regRdata_q <= 8'h00;
        end else if (regRd) begin
            case (regAddr)
                REG_CTRL:   regRdata_q <= {6'h00, ctrl_q};
                REG_KEY:    regRdata_q <= {6'h00, keyDead_q, keyArmed_q};
                REG_RESET_SOURCE_REGISTER: regRdata_q <= reset_source_register_q;
                REG_STATUS: regRdata_q <= {anyLocked_q, busy_q, lockCount_q};
                default:    regRdata_q <= 8'h00;
            endcase
        end else begin
            regRdata_q <= 8'h00;
        end
    end

    assign xramRead        = xmoveRead;
    assign flashReq        = flashReq_q;
    assign flashErrorReset = errRst_q;
    assign flashBusy       = busy_q;
    assign irqHold         = busy_q;
    assign regRdata        = regRdata_q;

    a_debug_no_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && req.fromDebug |=> !flashErrorReset)
        else $error("debug access caused reset");

    a_no_we_no_mod: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && !req.fromDebug && isModify && !ctrl_q[CTRL_WE_BIT]
        |=> !(flashReq.valid))
        else $error("modify without write enable");

    a_reserved_fw: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && !req.fromDebug && loaded_q && req.addr >= RESERVED_BASE
        |=> flashErrorReset)
        else $error("reserved firmware access not reset");

    a_lockpage_erase: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && !req.fromDebug && loaded_q && isErase
        && req.addr[ADDR_W-1:PAGE_BITS] == LOCK_PAGE |=> flashErrorReset)
        else $error("lock page erase not reset");

    a_supply_mon: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && !req.fromDebug && loaded_q && isModify && !supplyMonOn
        |=> flashErrorReset)
        else $error("modify without supply monitor");

    a_debug_locked: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && req.fromDebug && pageLocked(req.addr, lockCount_q)
        |=> !flashReq.valid)
        else $error("debug reached locked page");

    a_boundary_fixed: assert property (@(posedge core_clk) disable iff (!rst_n)
        loaded_q |=> $stable(lockCount_q))
        else $error("lock boundary moved");

    a_external_ram_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        xmoveRead |-> xramRead)
        else $error("external-move read not steered");

    a_erase_enables: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && !req.fromDebug && req.op == FSLG_OP_ERASE
        && !ctrl_q[CTRL_EE_BIT] |=> !flashReq.valid)
        else $error("erase without erase enable");

    a_fw_locked_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && !req.fromDebug && loaded_q && pageLocked(req.addr, lockCount_q)
        && !pageLocked(fetchAddr, lockCount_q) |=> flashErrorReset)
        else $error("locked page reached from unlocked code");

    a_lockbyte_change: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && !req.fromDebug && loaded_q && req.addr == LOCK_BYTE_ADDR
        && req.op == FSLG_OP_WRITE && anyLocked_q |=> flashErrorReset)
        else $error("lock byte change not reset");

    a_debug_lockbyte: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && req.fromDebug && req.addr == LOCK_BYTE_ADDR
        && req.op == FSLG_OP_WRITE |=> !flashReq.valid)
        else $error("debug changed lock byte");

    a_busy_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        flashReq.valid && flashReq.op != FSLG_OP_READ |-> flashBusy && irqHold)
        else $error("interrupts not held during modify");

    a_done_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
        flashDone && !(verdict == FSLG_ALLOW && isModify) |=> !flashBusy)
        else $error("busy outlived done");

    a_debug_open: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && req.fromDebug && loaded_q && req.addr < RESERVED_BASE
        && req.addr[ADDR_W-1:PAGE_BITS] != LOCK_PAGE
        && !pageLocked(req.addr, lockCount_q) |=> flashReq.valid)
        else $error("debug refused on unlocked page");

    a_lock_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        !loaded_q |=> loaded_q)
        else $error("lock byte not loaded");

    a_page_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        !loaded_q |=> lockCount_q == PAGE_W'(~$past(flashLockByte)))
        else $error("lock count wrong");

    a_load_ignore: assert property (@(posedge core_clk) disable iff (!rst_n)
        !loaded_q |=> !flashReq.valid && !flashErrorReset)
        else $error("request served before load");

    a_key_needed: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && !req.fromDebug && isModify && !keyArmed_q |=> !flashReq.valid)
        else $error("modify without key codes");

    a_key_dead: assert property (@(posedge core_clk) disable iff (!rst_n)
        keyDead_q |=> keyDead_q)
        else $error("dead key revived without reset");

    a_ferr_flag: assert property (@(posedge core_clk)
        !rst_n && ferrPending_q |=> reset_source_register_q[RST_FERR_BIT])
        else $error("flash error flag lost in reset");

    a_dbg_lockpg_erase: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && req.fromDebug && req.op == FSLG_OP_ERASE && anyLocked_q
        && req.addr[ADDR_W-1:PAGE_BITS] == LOCK_PAGE |=> !flashReq.valid)
        else $error("debug erased locked lock page");

    a_reserved_dbg: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && req.fromDebug && req.addr >= RESERVED_BASE |=> !flashReq.valid)
        else $error("debug reached reserved area");

    a_no_lock_open: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && !req.fromDebug && loaded_q && !anyLocked_q && req.op == FSLG_OP_READ
        && req.addr[ADDR_W-1:PAGE_BITS] == LOCK_PAGE |=> flashReq.valid)
        else $error("open lock page refused");

    a_erase_by_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        verdict == FSLG_ALLOW && !req.fromDebug && req.op == FSLG_OP_WRITE
        && ctrl_q[CTRL_EE_BIT] |=> flashReq.op == FSLG_OP_ERASE)
        else $error("erase-enabled write not an erase");

    a_mon_reset_en: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && !req.fromDebug && loaded_q && isModify && !supplyMonResetEn
        |=> flashErrorReset)
        else $error("modify without monitor reset source");

    a_erase_needs_we: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.valid && !req.fromDebug && req.op == FSLG_OP_ERASE
        && !ctrl_q[CTRL_WE_BIT] |=> !flashReq.valid)
        else $error("erase without write enable");

endmodule

// [test/fslg_flash_model.sv]
// Behavioural flash array beside the guard: holds the lock byte and times each modification.
// Assumes one modification at a time, as the bench waits for flashBusy to fall after each one.
`timescale 1ns/10ps

module fslg_flash_model
    import fslg_pkg::*;
(
    // Clock.
    input  wire logic        core_clk,
    // Guard side.
    input  wire fslg_flash_t flashReq,
    input  wire logic        debugFullErase,
    output logic             flashDone,
    output logic [7:0]       flashLockByte,
    // Bench controls.
    input  wire logic        slow,
    input  wire logic        presetEn,
    input  wire logic [7:0]  presetVal
);
    int waitCnt = 0;

    initial flashDone = 1'b0;
    initial flashLockByte = ERASED_BYTE;

    // The lock byte is non-volatile, so it ignores the system reset.
    always @(posedge core_clk) begin
        flashDone <= (waitCnt == 1);
        if (waitCnt > 0)
            waitCnt <= waitCnt - 1;
        if (flashReq.valid && flashReq.op != FSLG_OP_READ)
            waitCnt <= slow ? 20 : 1;
        if (presetEn)
            flashLockByte <= presetVal;
        else if (debugFullErase || (flashReq.valid && flashReq.op == FSLG_OP_ERASE
                 && flashReq.addr[ADDR_W-1:PAGE_BITS] == LOCK_PAGE))
            flashLockByte <= ERASED_BYTE;
        else if (flashReq.valid && flashReq.op == FSLG_OP_WRITE && flashReq.addr == LOCK_BYTE_ADDR)
            flashLockByte <= flashLockByte & flashReq.data;
    end
endmodule

// [test/fslg_guard_test.sv]
// Self-checking bench for the flash lock guard, with a reference verdict worked out per request.
// Assumes the flash model answers every allowed modification with a done pulse.
`timescale 1ns/10ps

module fslg_guard_test
    import fslg_pkg::*;
;
    logic              core_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [3:0]        regAddr = '0;
    logic [7:0]        regWdata = '0;
    logic              regWr = 1'b0;
    logic              regRd = 1'b0;
    logic [7:0]        regRdata;
    fslg_req_t         req = '0;
    logic              xmoveRead = 1'b0;
    logic [ADDR_W-1:0] fetchAddr = '0;
    logic              debugFullErase = 1'b0;
    logic              supplyMonOn = 1'b1;
    logic              supplyMonResetEn = 1'b1;
    logic [7:0]        flashLockByte;
    fslg_flash_t       flashReq;
    logic              xramRead, flashErrorReset, flashBusy, irqHold, flashDone;
    logic              slow = 1'b0, presetEn = 1'b0;
    logic [7:0]        presetVal = '0;
    logic [7:0]        r;
    int                badCount = 0, nTests = 0, cycles = 0, lockNow = 0;

    always #5 core_clk = ~core_clk;

    fslg_guard dut_u (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .req(req),
        .xmoveRead(xmoveRead), .fetchAddr(fetchAddr), .debugFullErase(debugFullErase),
        .supplyMonOn(supplyMonOn), .supplyMonResetEn(supplyMonResetEn),
        .flashLockByte(flashLockByte), .flashReq(flashReq), .xramRead(xramRead),
        .flashErrorReset(flashErrorReset), .flashBusy(flashBusy), .irqHold(irqHold),
        .flashDone(flashDone));

    fslg_flash_model flash_u (.core_clk(core_clk), .flashReq(flashReq),
        .debugFullErase(debugFullErase), .flashDone(flashDone), .flashLockByte(flashLockByte),
        .slow(slow), .presetEn(presetEn), .presetVal(presetVal));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic completeRun();
        if (badCount == 0 && nTests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            completeRun();
        end
    end

    task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    task automatic regRead(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    // The lock byte is taken only at reset, so the reference boundary is refreshed here.
    task automatic doReset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        lockNow = flashLockByte;
    endtask

    // Verdict codes: 0 allowed, 1 ignored, 2 flash error reset.
    function automatic int verdict(logic dbg, fslg_op_t op, int a, int fa, logic [1:0] ctl);
        int  n = (~lockNow) & 255;
        int  pg = a >> 9;
        bit  anyLk = (lockNow != 255);
        bit  pLk = (pg < n) || (pg == LOCK_PAGE && anyLk);
        bit  md = (op != FSLG_OP_READ);
        if (dbg)
            return (a >= RESERVED_BASE || pLk) ? 1 : 0;
        if (a >= RESERVED_BASE)
            return 2;
        if (md && !ctl[0])
            return 1;
        if (md && !(supplyMonOn && supplyMonResetEn))
            return 2;
        if (md && ((ctl[1] && pg == LOCK_PAGE) || (a == LOCK_BYTE_ADDR && anyLk)))
            return 2;
        return (pLk && (fa >> 9) >= n) ? 2 : 0;
    endfunction

    task automatic access(input logic dbg, input fslg_op_t op, input logic [14:0] a,
                          input logic [14:0] fa, input logic [1:0] ctl, input logic [7:0] d);
        int       v;
        fslg_op_t eop;
        eop = (!dbg && op == FSLG_OP_WRITE && ctl[1]) ? FSLG_OP_ERASE : op;
        if (!dbg && op != FSLG_OP_READ) begin
            regWrite(REG_CTRL, {6'h00, ctl});
            regWrite(REG_KEY, KEY_FIRST);
            regWrite(REG_KEY, KEY_SECOND);
        end
        @(posedge core_clk);
        v = verdict(dbg, op, a, fa, ctl);
        fetchAddr <= fa;
        xmoveRead <= 1'($urandom);
        req <= '{1'b1, dbg, op, a, d};
        @(posedge core_clk);
        req.valid <= 1'b0;
        #1;
        check("external_ram read", xramRead, xmoveRead);
        check("error reset", flashErrorReset, v == 2);
        check("grant", flashReq.valid, v == 0);
        if (v == 0)
            check("flash request", {flashReq.op, flashReq.addr, eop == FSLG_OP_WRITE ?
                  flashReq.data : 8'h00}, {eop, a, eop == FSLG_OP_WRITE ? d : 8'h00});
        if (v == 0 && op != FSLG_OP_READ) begin
            @(posedge core_clk);
            #1;
            check("irq hold", {irqHold, flashBusy}, 2'h3);
            for (int i = 0; i < 40 && flashBusy !== 1'b0; i++)
                @(posedge core_clk);
            #1;
            check("busy end", flashBusy, 1'b0);
        end
        if (v == 2) begin
            doReset();
            regRead(REG_RESET_SOURCE_REGISTER, r);
            check("error flag", r[RST_FERR_BIT], 1'b1);
            regWrite(REG_RESET_SOURCE_REGISTER, 8'h02);
            regRead(REG_RESET_SOURCE_REGISTER, r);
            check("flag clear", r[RST_FERR_BIT], 1'b0);
        end
    endtask

    initial begin
        logic [5:0] pages [7] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h05, 6'h3E, 6'h3F};
        logic [5:0] fpages [3] = '{6'h00, 6'h02, 6'h05};
        logic       dbg;
        fslg_op_t   op;
        logic [14:0] a;
        void'($urandom(32'h368251DA));
        @(posedge core_clk);
        presetEn <= 1'b1;
        presetVal <= 8'hFC;
        @(posedge core_clk);
        presetEn <= 1'b0;
        doReset();
        regRead(REG_STATUS, r);
        check("status", r, 8'h83);
        regRead(REG_CTRL, r);
        check("control", r, 8'h00);
        access(1'b0, FSLG_OP_WRITE, 15'h0A10, 15'h0A00, 2'h0, 8'h5A);
        access(1'b0, FSLG_OP_WRITE, 15'h0A10, 15'h0A00, 2'h2, 8'h5A);
        access(1'b0, FSLG_OP_WRITE, 15'h0A10, 15'h0A00, 2'h3, 8'h5A);
        access(1'b0, FSLG_OP_WRITE, LOCK_BYTE_ADDR, 15'h0400, 2'h1, 8'h00);
        @(posedge core_clk);
        supplyMonOn <= 1'b0;
        access(1'b0, FSLG_OP_WRITE, 15'h0A10, 15'h0A00, 2'h1, 8'h11);
        @(posedge core_clk);
        supplyMonOn <= 1'b1;
        supplyMonResetEn <= 1'b0;
        access(1'b0, FSLG_OP_WRITE, 15'h0A10, 15'h0A00, 2'h1, 8'h11);
        @(posedge core_clk);
        supplyMonResetEn <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            dbg = 1'($urandom);
            a = {pages[$urandom % 7], 9'($urandom)};
            op = fslg_op_t'($urandom % (dbg ? 3 : 2));
            if (dbg && a == LOCK_BYTE_ADDR)
                op = FSLG_OP_READ;
            @(posedge core_clk);
            slow <= 1'($urandom);
            access(dbg, op, a, {fpages[$urandom % 3], 9'h000}, {1'($urandom), 1'b1}, 8'($urandom));
        end
        @(posedge core_clk);
        debugFullErase <= 1'b1;
        @(posedge core_clk);
        debugFullErase <= 1'b0;
        doReset();
        regRead(REG_STATUS, r);
        check("status", r, 8'h00);
        access(1'b0, FSLG_OP_WRITE, LOCK_BYTE_ADDR, 15'h0A00, 2'h1, 8'hF8);
        regRead(REG_STATUS, r);
        check("status", r, 8'h00);
        doReset();
        regRead(REG_STATUS, r);
        check("status", r, 8'h87);
        completeRun();
    end
endmodule
